// [dpbr_pkg.sv]
// constants, field layout and carrier types of the dual-port block memory
// assumes nothing of its surroundings; imported whole by every module
package dpbr_pkg;

	// geometry
	localparam int unsigned DPBR_SLOTS = 4;
	localparam int unsigned DPBR_ADDR_W = 15;
	localparam int unsigned DPBR_DATA_W = 64;
	localparam int unsigned DPBR_PAR_W = 8;
	localparam int unsigned DPBR_DATA_BITS = 32768;
	localparam int unsigned DPBR_PAR_BITS = 4096;
	localparam int unsigned DPBR_WIDE_36K = 36;
	localparam int unsigned DPBR_WIDE_18K = 18;

	// register port
	localparam int unsigned DPBR_REG_AW = 4;
	localparam logic [3:0] DPBR_OFS_CTRL = 4'h0;
	localparam logic [3:0] DPBR_OFS_STATUS = 4'h4;
	localparam logic [3:0] DPBR_OFS_INFO = 4'h8;

	// control word fields
	localparam int unsigned DPBR_CTRL_WMODE_LSB = 0;
	localparam int unsigned DPBR_CTRL_OREG_LSB = 8;
	localparam int unsigned DPBR_CTRL_LATCH_LSB = 12;
	localparam int unsigned DPBR_CTRL_SLEEP_BIT = 16;
	localparam logic [31:0] DPBR_CTRL_RESET = 32'h0000f000;
	localparam logic [31:0] DPBR_CTRL_MASK = 32'h0001ffff;

	// status word fields
	localparam int unsigned DPBR_STS_REFUSED_LSB = 0;
	localparam int unsigned DPBR_STS_ASLEEP_BIT = 4;
	localparam int unsigned DPBR_STS_SPLIT_BIT = 5;
	localparam int unsigned DPBR_STS_SRW_BIT = 6;

	typedef enum logic [1:0] {
		DPBR_WM_READ_FIRST,
		DPBR_WM_WRITE_FIRST,
		DPBR_WM_NO_CHANGE
	} dpbr_wmode_e;

	// one request from user logic
	typedef struct packed {
		logic en;
		logic we;
		logic bank;
		logic [DPBR_ADDR_W-1:0] addr;
		logic [DPBR_DATA_W-1:0] din;
		logic [DPBR_PAR_W-1:0] dinp;
	} dpbr_req_s;

	// registered request mapped onto the bit array
	typedef struct packed {
		logic en;
		logic we;
		logic bank;
		logic [14:0] dBase;
		logic [11:0] pBase;
		logic [DPBR_DATA_W-1:0] dBits;
		logic [DPBR_PAR_W-1:0] pBits;
		logic [6:0] dCnt;
		logic [3:0] pCnt;
	} dpbr_acc_s;

	// parity in [71:64], data in [63:0]
	typedef logic [DPBR_PAR_W+DPBR_DATA_W-1:0] dpbr_word_t;

endpackage

// [dpbr_port_in.sv]
// input register of one memory port and its mapping onto the bit array
// assumes the request comes from logic on sys_clk
`timescale 1ns/10ps
module dpbr_port_in
	import dpbr_pkg::*;
#(
	parameter int unsigned PORT_W = 36,
	parameter bit SPLIT = 1'b0,
	parameter bit HALF = 1'b0
) (
	// clock and reset
	input logic sys_clk,
	input logic rst_n,
	// request and address latch option
	input dpbr_req_s req,
	input logic latchEn,
	// access toward the array
	output dpbr_acc_s acc
);
	localparam bit PAR = (PORT_W % 9) == 0;
	localparam int unsigned NB = PAR ? PORT_W / 9 : 0;
	localparam int unsigned DW = PAR ? NB * 8 : PORT_W;
	localparam int unsigned DSH = $clog2(DW);
	localparam int unsigned PSH = $clog2(NB);

	dpbr_req_s s_r;
	dpbr_req_s s_nxt;
	logic [14:0] useAddr;
	logic [31:0] dFull;
	logic [31:0] pFull;

	always_comb begin
		s_nxt = req;
		if (!req.en) begin
			s_nxt.addr = s_r.addr;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// with latching off the live address drives the access
	assign useAddr = latchEn ? s_r.addr : req.addr;
	assign dFull = 32'(useAddr) << DSH;
	assign pFull = 32'(useAddr) << PSH;

	always_comb begin
		acc = '0;
		acc.en = s_r.en;
		acc.we = s_r.we;
		acc.bank = s_r.bank;
		acc.dBase = SPLIT ? {HALF, dFull[13:0]} : dFull[14:0];
		acc.pBase = SPLIT ? {HALF, pFull[10:0]} : pFull[11:0];
		for (int i = 0; i < DPBR_DATA_W; i++) begin
			acc.dBits[i] = (i < DW) ? s_r.din[i] : 1'b0;
		end
		for (int i = 0; i < DPBR_PAR_W; i++) begin
			acc.pBits[i] = (i < NB) ? s_r.dinp[i] : 1'b0;
		end
		acc.dCnt = 7'(DW);
		acc.pCnt = 4'(NB);
	end

endmodule

// [dpbr_port_out.sv]
// read latch, write-mode selection, output pipeline and cascade pick of one port
// assumes old and new words are settled in the access cycle
`timescale 1ns/10ps
module dpbr_port_out
	import dpbr_pkg::*;
#(
	parameter bit CAS_LOWER = 1'b0
) (
	// clock and reset
	input logic sys_clk,
	input logic rst_n,
	// access of this cycle
	input logic doRead,
	input logic doWrite,
	input logic casAcc,
	input dpbr_wmode_e wmode,
	input logic outReg,
	input dpbr_word_t oldWord,
	input dpbr_word_t newWord,
	// cascade data from the neighbour
	input dpbr_word_t casIn,
	// outputs
	output dpbr_word_t dout,
	output dpbr_word_t casOut
);
	typedef struct packed {
		dpbr_word_t latch;
		logic selUp;
		dpbr_word_t dout;
	} dpbr_out_s;

	dpbr_out_s s_r;
	dpbr_out_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (doRead) begin
			s_nxt.latch = oldWord;
		end else if (doWrite) begin
			unique case (wmode)
				DPBR_WM_READ_FIRST: s_nxt.latch = oldWord;
				DPBR_WM_WRITE_FIRST: s_nxt.latch = newWord;
				DPBR_WM_NO_CHANGE: s_nxt.latch = s_r.latch;
				default: s_nxt.latch = s_r.latch;
			endcase
		end
		if (doRead || doWrite || casAcc) begin
			s_nxt.selUp = casAcc && CAS_LOWER;
		end
		// lower cascade end always uses the pipeline stage to meet its neighbour
		if (outReg || CAS_LOWER) begin
			s_nxt.dout = s_r.selUp ? casIn : s_r.latch;
		end else begin
			s_nxt.dout = s_nxt.latch;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dout = s_r.dout;
	assign casOut = s_r.latch;

endmodule

// [dpbr_ram.sv]
// dual-port block memory: bit array, port slots, control and status registers
// assumes user logic on sys_clk drives every port slot and the register port
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module dpbr_ram
	import dpbr_pkg::*;
#(
	parameter logic [3:0][6:0] PORT_W = {7'd36, 7'd36, 7'd36, 7'd36},
	parameter bit SPLIT = 1'b0,
	parameter bit SRW = 1'b0,
	parameter bit INST_USED = 1'b1,
	parameter bit CAS_POS = 1'b0,
	parameter bit CAS_LOWER = 1'b0
) (
	// clock and reset
	input logic sys_clk,
	input logic rst_n,
	// register port
	input logic [DPBR_REG_AW-1:0] regAddr,
	input logic [31:0] regWdata,
	input logic regWr,
	input logic regRd,
	output logic [31:0] regRdata,
	// memory port slots, slot = half * 2 + port
	input dpbr_req_s [DPBR_SLOTS-1:0] portReq,
	output dpbr_word_t [DPBR_SLOTS-1:0] portDout,
	// power gating
	input logic pwrGate,
	output logic pwrAsleep,
	// cascade to the vertical neighbour
	input dpbr_word_t [DPBR_SLOTS-1:0] casDataIn,
	output dpbr_word_t [DPBR_SLOTS-1:0] casDataOut
);
	typedef struct packed {
		logic [DPBR_DATA_BITS-1:0] dataMem;
		logic [DPBR_PAR_BITS-1:0] parMem;
		logic [31:0] ctrl;
		logic [DPBR_SLOTS-1:0] refused;
		logic asleep;
		logic [31:0] rdata;
	} dpbr_main_s;

	dpbr_main_s s_r;
	dpbr_main_s s_nxt;

	dpbr_acc_s [DPBR_SLOTS-1:0] acc;
	dpbr_word_t [DPBR_SLOTS-1:0] oldWord;
	dpbr_word_t [DPBR_SLOTS-1:0] newWord;
	logic [DPBR_SLOTS-1:0] mine;
	logic [DPBR_SLOTS-1:0] wrOk;
	logic [DPBR_SLOTS-1:0] rdOk;
	logic [DPBR_SLOTS-1:0] refuse;
	logic [DPBR_SLOTS-1:0] casAcc;
	logic [DPBR_SLOTS-1:0] stsClr;
	logic [31:0] statusWord;
	logic [31:0] infoWord;
	logic sleepNow;
	// per-slot control fields, sliced once from the control word
	dpbr_wmode_e [DPBR_SLOTS-1:0] slotMode;
	logic [DPBR_SLOTS-1:0] slotOreg;
	logic [DPBR_SLOTS-1:0] slotLatch;

	// every depth-by-width shape a port may take
	function automatic bit shapeOk(input int unsigned w);
		case (w)
			1, 2, 4, 8, 9: begin
				return 1'b1;
			end
			16, 18, 32, 36: begin
				return 1'b1;
			end
			64, 72: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction

	function automatic bit fixedSide(input int unsigned w);
		if (w == 32 || w == 36) begin
			return 1'b1;
		end
		// the 64/72 pair only exists in the full-size memory
		if (SPLIT) begin
			return 1'b0;
		end
		return w == 64 || w == 72;
	endfunction

	// register write decode, shared by the control and status paths
	function automatic bit regHit(
		input logic wr,
		input logic [DPBR_REG_AW-1:0] a,
		input logic [DPBR_REG_AW-1:0] ofs
	);
		return wr && a == ofs;
	endfunction

	// shape legality of one slot, judged in SRW mode against its partner port, otherwise against the 36 or 18 width limit
	function automatic bit slotLegal(input int unsigned p);
		int unsigned w;
		int unsigned other;
		int unsigned lim;
		w = PORT_W[p];
		other = PORT_W[p ^ 1];
		lim = SPLIT ? DPBR_WIDE_18K : DPBR_WIDE_36K;
		if (!shapeOk(w)) begin
			return 1'b0;
		end
		if (SPLIT && w > DPBR_WIDE_36K) begin
			return 1'b0;
		end
		if (!SRW) begin
			return w <= lim;
		end
		return fixedSide(w) || fixedSide(other);
	endfunction

	// data bit index; a split half wraps inside its own 16K bits
	function automatic logic [14:0] dIdx(input logic [14:0] base, input int unsigned i);
		logic [14:0] sum;
		sum = base + i[14:0];
		return SPLIT ? {base[14], sum[13:0]} : sum;
	endfunction

	function automatic logic [11:0] pIdx(input logic [11:0] base, input int unsigned i);
		logic [11:0] sum;
		sum = base + i[11:0];
		return SPLIT ? {base[11], sum[10:0]} : sum;
	endfunction

	function automatic dpbr_word_t rdWord(
		input logic [DPBR_DATA_BITS-1:0] dm,
		input logic [DPBR_PAR_BITS-1:0] pm,
		input dpbr_acc_s a
	);
		dpbr_word_t w;
		w = '0;
		for (int i = 0; i < DPBR_DATA_W; i++) begin
			if (i < a.dCnt) begin
				w[i] = dm[dIdx(a.dBase, i)];
			end
		end
		for (int i = 0; i < DPBR_PAR_W; i++) begin
			if (i < a.pCnt) begin
				w[DPBR_DATA_W+i] = pm[pIdx(a.pBase, i)];
			end
		end
		return w;
	endfunction

	for (genvar g = 0; g < DPBR_SLOTS; g++) begin : gSlot
		localparam bit LEGAL = slotLegal(g);
		localparam bit ACTIVE = SPLIT || (g < 2);
		localparam bit WR_ONLY = SRW && (g % 2 == 0);
		localparam bit RD_ONLY = SRW && (g % 2 == 1);

		assign slotMode[g] = dpbr_wmode_e'(s_r.ctrl[DPBR_CTRL_WMODE_LSB+2*g +: 2]);
		assign slotOreg[g] = s_r.ctrl[DPBR_CTRL_OREG_LSB+g];
		assign slotLatch[g] = s_r.ctrl[DPBR_CTRL_LATCH_LSB+g];

		dpbr_port_in #(
			.PORT_W(32'(PORT_W[g])),
			.SPLIT(SPLIT),
			.HALF(g >= 2)
		) uIn (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.req(portReq[g]),
			.latchEn(slotLatch[g]),
			.acc(acc[g])
		);

		// each slot qualifies on its own; slots share only the array
		assign mine[g] = acc[g].en && ACTIVE && (acc[g].bank == CAS_POS);
		assign casAcc[g] = acc[g].en && ACTIVE && (acc[g].bank != CAS_POS);
		assign wrOk[g] = mine[g] && LEGAL && !s_r.asleep && acc[g].we && !RD_ONLY;
		assign rdOk[g] = mine[g] && LEGAL && !s_r.asleep && !acc[g].we && !WR_ONLY;
		assign refuse[g] = mine[g] && !wrOk[g] && !rdOk[g];
		assign oldWord[g] = rdWord(s_r.dataMem, s_r.parMem, acc[g]);
		assign newWord[g] = {acc[g].pBits, acc[g].dBits};

		dpbr_port_out #(
			.CAS_LOWER(CAS_LOWER)
		) uOut (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.doRead(rdOk[g]),
			.doWrite(wrOk[g]),
			.casAcc(casAcc[g]),
			.wmode(slotMode[g]),
			.outReg(slotOreg[g]),
			.oldWord(oldWord[g]),
			.newWord(newWord[g]),
			.casIn(casDataIn[g]),
			.dout(portDout[g]),
			.casOut(casDataOut[g])
		);
	end

	assign stsClr = regHit(regWr, regAddr, DPBR_OFS_STATUS) ? regWdata[3:0] : '0;
	assign infoWord = {4'h0, PORT_W};

	// a gated or unused instance refuses every access but keeps its contents
	assign sleepNow = !INST_USED || pwrGate || s_r.ctrl[DPBR_CTRL_SLEEP_BIT];

	always_comb begin
		statusWord = '0;
		statusWord[DPBR_STS_REFUSED_LSB +: DPBR_SLOTS] = s_r.refused;
		statusWord[DPBR_STS_ASLEEP_BIT] = s_r.asleep;
		statusWord[DPBR_STS_SPLIT_BIT] = SPLIT;
		statusWord[DPBR_STS_SRW_BIT] = SRW;
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = '0;
		s_nxt.asleep = sleepNow;
		// a later slot wins when two write the same bit in one cycle
		for (int p = 0; p < DPBR_SLOTS; p++) begin
			if (wrOk[p]) begin
				for (int i = 0; i < DPBR_DATA_W; i++) begin
					if (i < acc[p].dCnt) begin
						s_nxt.dataMem[dIdx(acc[p].dBase, i)] = acc[p].dBits[i];
					end
				end
				for (int i = 0; i < DPBR_PAR_W; i++) begin
					if (i < acc[p].pCnt) begin
						s_nxt.parMem[pIdx(acc[p].pBase, i)] = acc[p].pBits[i];
					end
				end
			end
		end
		// a refusal in the clearing cycle survives the clear
		s_nxt.refused = (s_r.refused & ~stsClr) | refuse;
		if (regHit(regWr, regAddr, DPBR_OFS_CTRL)) begin
			s_nxt.ctrl = regWdata & DPBR_CTRL_MASK;
		end
		if (regRd) begin
			unique case (regAddr)
				DPBR_OFS_CTRL: s_nxt.rdata = s_r.ctrl;
				DPBR_OFS_STATUS: s_nxt.rdata = statusWord;
				DPBR_OFS_INFO: s_nxt.rdata = infoWord;
				default: s_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r.dataMem <= '0;
			s_r.parMem <= '0;
			s_r.ctrl <= DPBR_CTRL_RESET;
			s_r.refused <= '0;
			s_r.asleep <= 1'b0;
			s_r.rdata <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign regRdata = s_r.rdata;
	assign pwrAsleep = s_r.asleep;

endmodule

// [dpbr_ram_props.sv]
// checker of the dual-port block memory, on the top module ports only
// assumes one sys_clk domain and CTRL changed only through the register port
`timescale 1ns/10ps
module dpbr_ram_props
	import dpbr_pkg::*;
#(
	parameter logic [3:0][6:0] PORT_W = {7'h24, 7'h24, 7'h24, 7'h24},
	parameter bit SPLIT = 1'h0,
	parameter bit INST_USED = 1'h1,
	parameter bit CAS_LOWER = 1'h0
) (
	// clock and reset
	input logic sys_clk,
	input logic rst_n,
	// register port
	input logic [DPBR_REG_AW-1:0] regAddr,
	input logic [31:0] regWdata,
	input logic regWr,
	input logic regRd,
	input logic [31:0] regRdata,
	// memory slots, power, cascade
	input dpbr_req_s [DPBR_SLOTS-1:0] portReq,
	input dpbr_word_t [DPBR_SLOTS-1:0] portDout,
	input logic pwrGate,
	input logic pwrAsleep,
	input dpbr_word_t [DPBR_SLOTS-1:0] casDataIn,
	input dpbr_word_t [DPBR_SLOTS-1:0] casDataOut
);
	logic [31:0] ctrl_r;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// shadow of the control word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= DPBR_CTRL_RESET;
		end else if (regWr && regAddr == DPBR_OFS_CTRL) begin
			ctrl_r <= regWdata & DPBR_CTRL_MASK;
		end
	end
	// lone awake write on slot 0 with a given mode and output register
	sequence s_wr0(logic [1:0] m, logic o);
		portReq[0].en && portReq[0].we && !portReq[0].bank && !portReq[1].en && !pwrAsleep
			&& !pwrGate && !ctrl_r[16] && ctrl_r[12] && ctrl_r[1:0] == m && ctrl_r[8] == o;
	endsequence
	property p_wf_plain;
		s_wr0(2'h1, 1'h0) |-> ##2 portDout[0][31:0] == $past(portReq[0].din[31:0], 2)
			&& portDout[0][67:64] == $past(portReq[0].dinp[3:0], 2);
	endproperty
	a_wf_plain: assert property (p_wf_plain)
		else $error("new data not shown two cycles after write");
	property p_wf_oreg;
		s_wr0(2'h1, 1'h1) |-> ##3 portDout[0][31:0] == $past(portReq[0].din[31:0], 3);
	endproperty
	a_wf_oreg: assert property (p_wf_oreg)
		else $error("output register latency wrong");
	property p_nochg;
		s_wr0(2'h2, 1'h0) |-> ##2 $stable(portDout[0]);
	endproperty
	a_nochg: assert property (p_nochg)
		else $error("output moved on a no-change write");
	property p_hold;
		(!portReq[0].en && $stable(ctrl_r)) [*3] |=> $stable(portDout[0]) || !$stable(ctrl_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("output moved with no access");
	property p_gate;
		pwrGate |=> pwrAsleep;
	endproperty
	a_gate: assert property (p_gate)
		else $error("gate did not put the memory asleep");
	property p_wake;
		!pwrGate && !ctrl_r[16] |=> pwrAsleep == !INST_USED;
	endproperty
	a_wake: assert property (p_wake)
		else $error("asleep flag wrong while not gated");
	property p_unused;
		!SPLIT |-> portDout[2] == '0 && portDout[3] == '0;
	endproperty
	a_unused: assert property (p_unused)
		else $error("unused half drives data");
	property p_upper;
		PORT_W[0] == 7'h24 |-> portDout[0][63:32] == '0 && portDout[0][71:68] == '0;
	endproperty
	a_upper: assert property (p_upper)
		else $error("bits above slot width not zero");
	property p_casout;
		!CAS_LOWER && !$past(ctrl_r[8]) |-> casDataOut[0] == portDout[0];
	endproperty
	a_casout: assert property (p_casout)
		else $error("cascade output differs from unregistered read data");
	c_wf: cover property (s_wr0(2'h1, 1'h0));
	c_oreg: cover property (s_wr0(2'h1, 1'h1));
	c_gate: cover property (pwrGate ##1 pwrAsleep);
endmodule
bind dpbr_ram dpbr_ram_props #(.PORT_W(PORT_W), .SPLIT(SPLIT), .INST_USED(INST_USED),
	.CAS_LOWER(CAS_LOWER)) props_u (
	.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.regRd(regRd), .regRdata(regRdata), .portReq(portReq), .portDout(portDout),
	.pwrGate(pwrGate), .pwrAsleep(pwrAsleep), .casDataIn(casDataIn), .casDataOut(casDataOut));

// [dpbr_ram_tb.sv]
// bench of the dual-port block memory: table of slot cases, then hand tests
// assumes the default build, one 36Kb memory with 36-bit slots
`timescale 1ns/10ps
module dpbr_ram_tb
	import dpbr_pkg::*;
;
	typedef struct packed {logic w; logic [14:0] a; logic [35:0] d; logic [35:0] x;} dpbr_row_s;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'h0;
	logic regRd = 1'h0;
	logic [31:0] regRdata;
	logic [31:0] rd;
	wire dpbr_req_s [3:0] portReq;
	dpbr_word_t [3:0] portDout;
	wire pwrGate;
	logic pwrAsleep;
	int num_errors = 0;
	int check_count = 0;
	dpbr_row_s rows [6] = '{
		'{1'h1, 15'h0, 36'h5_1234_5678, 36'h0},
		'{1'h1, 15'h0, 36'ha_8765_4321, 36'h5_1234_5678},
		'{1'h0, 15'h0, 36'h0, 36'ha_8765_4321},
		'{1'h1, 15'h3ff, 36'hf_ffff_ffff, 36'h0},
		'{1'h0, 15'h400, 36'h0, 36'ha_8765_4321},
		'{1'h0, 15'h3ff, 36'h0, 36'hf_ffff_ffff}
	};
	always #4 sys_clk = ~sys_clk;
	assign portReq[3:2] = '0;
	dpbr_user u0 (.sys_clk(sys_clk), .req(portReq[0]), .pwrGate(pwrGate));
	dpbr_user u1 (.sys_clk(sys_clk), .req(portReq[1]), .pwrGate());
	dpbr_ram dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .portReq(portReq),
		.portDout(portDout), .pwrGate(pwrGate), .pwrAsleep(pwrAsleep), .casDataIn('0),
		.casDataOut());
	task automatic chk(input logic [71:0] s, input logic [71:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one register cycle; read data taken in the following cycle
	task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= w;
		regRd <= !w;
		@(posedge sys_clk);
		regWr <= 1'h0;
		regRd <= 1'h0;
		#1 rd = regRdata;
	endtask
	function automatic dpbr_word_t w36(input logic [35:0] d);
		return {4'h0, d[35:32], 32'h0, d[31:0]};
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge sys_clk);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'h1;
		@(posedge sys_clk);
		rw(1'h0, DPBR_OFS_CTRL, 32'h0);
		chk(rd, DPBR_CTRL_RESET);
		rw(1'h0, DPBR_OFS_INFO, 32'h0);
		chk(rd, {4'h0, {4{7'h24}}});
		rw(1'h1, 4'hc, 32'hffff_ffff);
		rw(1'h0, 4'hc, 32'h0);
		chk(rd, 32'h0);
		$display("registers done");
		foreach (rows[i]) begin
			u0.op(rows[i].w, rows[i].a, rows[i].d);
			u0.idle();
			#1 chk(portDout[0], w36(rows[i].x));
		end
		$display("table done");
		// write then read of the same word on back-to-back cycles
		rw(1'h1, DPBR_OFS_CTRL, 32'h0000_f001);
		u0.op(1'h1, 15'h5, 36'h9_0000_0005);
		u0.op(1'h0, 15'h5, 36'h0);
		#1 chk(portDout[0], w36(36'h9_0000_0005));
		u0.idle();
		#1 chk(portDout[0], w36(36'h9_0000_0005));
		rw(1'h1, DPBR_OFS_CTRL, 32'h0000_f002);
		u0.op(1'h1, 15'h5, 36'h3_3333_3333);
		u0.idle();
		#1 chk(portDout[0], w36(36'h9_0000_0005));
		u0.op(1'h0, 15'h5, 36'h0);
		u0.idle();
		#1 chk(portDout[0], w36(36'h3_3333_3333));
		$display("write modes done");
		rw(1'h1, DPBR_OFS_CTRL, 32'h0000_f101);
		u0.op(1'h1, 15'h7, 36'h7_7777_7777);
		u0.idle();
		#1 chk(portDout[0] === w36(36'h7_7777_7777), 1'h0);
		u0.idle();
		#1 chk(portDout[0], w36(36'h7_7777_7777));
		$display("output register done");
		// second port reads while the first writes the same word
		fork
			u0.op(1'h1, 15'h8, 36'h8_8888_8888);
			u1.op(1'h0, 15'h8, 36'h0);
		join
		u1.idle();
		#1 chk(portDout[1], w36(36'h0));
		u1.op(1'h0, 15'h8, 36'h0);
		u1.idle();
		#1 chk(portDout[1], w36(36'h8_8888_8888));
		$display("two ports done");
		u0.gate(1'h1);
		@(posedge sys_clk);
		#1 chk(pwrAsleep, 1'h1);
		u0.op(1'h1, 15'h8, 36'h1_0000_0001);
		u0.idle();
		u0.gate(1'h0);
		u0.op(1'h0, 15'h8, 36'h0);
		u0.idle();
		u0.idle();
		#1 chk(portDout[0], w36(36'h8_8888_8888));
		rw(1'h0, DPBR_OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		rw(1'h1, DPBR_OFS_STATUS, 32'h1);
		rw(1'h0, DPBR_OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		$display("power gate done");
		rst_n <= 1'h0;
		#1 chk(portDout[0], 72'h0);
		#8 rst_n <= 1'h1;
		@(posedge sys_clk);
		rw(1'h0, DPBR_OFS_CTRL, 32'h0);
		chk(rd, DPBR_CTRL_RESET);
		u1.op(1'h0, 15'h8, 36'h0);
		u1.idle();
		#1 chk(portDout[1], 72'h0);
		$display("reset done");
		tally_and_finish();
	end
endmodule

// [dpbr_user.sv]
// user logic model driving one memory slot and the power gate
// assumes its tasks are entered just after a rising edge of sys_clk
`timescale 1ns/10ps
module dpbr_user
	import dpbr_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// request and power gate toward the memory
	output dpbr_req_s req,
	output logic pwrGate
);
	initial req = '0;
	initial pwrGate = 1'h0;
	// request held up to the edge that takes it
	task automatic op(input logic w, input logic [14:0] a, input logic [35:0] d);
		req <= '{1'h1, w, 1'h0, a, {32'h0, d[31:0]}, {4'h0, d[35:32]}};
		@(posedge sys_clk);
	endtask
	// released lines show a changed pattern, not the last value
	task automatic idle();
		req <= '{1'h0, 1'h0, 1'h0, ~req.addr, ~req.din, ~req.dinp};
		@(posedge sys_clk);
	endtask
	task automatic gate(input logic v);
		pwrGate <= v;
		@(posedge sys_clk);
	endtask
endmodule
